// ---- bench/fpmpp_host.sv ----
// host-side parallel programmer model for the flash port bench
`timescale 1ns/100ps
`default_nettype none
module fpmpp_host (
    input wire logic ref_clk,
    output logic sel,
    output logic [10:0] addr,
    output logic rc,
    output logic we_n,
    output logic oe_n,
    output logic [7:0] dq
);
    // strap settles at time zero, long before any reset release
    initial begin
        sel = 1'b1;
        addr = 11'h000;
        rc = 1'b1;
        we_n = 1'b1;
        oe_n = 1'b1;
        dq = 8'h00;
    end
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step
    // the column stays on the pins afterwards, else the next edge reloads it
    task automatic put_addr(input logic [10:0] row, input logic [10:0] col);
        rc = 1'b1;
        addr = row;
        step();
        rc = 1'b0;
        addr = col;
        step();
    endtask : put_addr
    task automatic wr(input logic [7:0] d, input logic [10:0] late_col);
        we_n = 1'b0;
        dq = d;
        step();
        we_n = 1'b1;
        // released data must not keep showing the old byte
        dq = ~d;
        addr = late_col;
        step();
    endtask : wr
endmodule : fpmpp_host
`default_nettype wire

// ---- bench/fpmpp_port_tb.sv ----
// self-checking bench for the flash pin-mode and parallel port
`timescale 1ns/100ps
`default_nettype none
module fpmpp_port_tb;
    import fpmpp_pkg::*;
    typedef struct {logic [10:0] row; logic [10:0] col; logic [7:0] d;} fpmpp_rd_row_t;
    logic ref_clk;
    logic reset_n;
    logic [7:0] rd_data;
    logic [3:0] nib_tx;
    logic nib_en;
    wire logic sel, rc, we_n, oe_n, int_rst_n, pmode, wr_valid, frame;
    wire logic [10:0] addr;
    wire logic [7:0] h_dq, pin, dq_out, dq_oe, wr_data;
    wire logic [21:0] rd_addr, wr_addr;
    wire logic [3:0] nib;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    fpmpp_rd_row_t rows [4] = '{'{11'h7FF, 11'h000, 8'hA5}, '{11'h000, 11'h7FF, 8'h5A},
        '{11'h555, 11'h2AA, 8'hFF}, '{11'h001, 11'h400, 8'h00}};
    assign pin = (dq_oe & dq_out) | (~dq_oe & h_dq);
    fpmpp_host host (.ref_clk(ref_clk), .sel(sel), .addr(addr), .rc(rc), .we_n(we_n),
        .oe_n(oe_n), .dq(h_dq));
    fpmpp_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .init_pin_n(oe_n),
        .port_style_select(sel), .low_address_pins(addr[9:0]), .top_mux_address_pin(addr[10]),
        .row_col_sel(rc), .we_frame_pin(we_n), .dq_in(pin), .dq_out(dq_out), .dq_oe(dq_oe),
        .int_rst_n(int_rst_n), .parallel_programming_mode(pmode), .core_rd_addr(rd_addr),
        .core_rd_data(rd_data), .core_wr_valid(wr_valid), .core_wr_addr(wr_addr),
        .core_wr_data(wr_data), .hub_nibble_lines(nib), .hub_frame_input(frame),
        .hub_nib_tx(nib_tx), .hub_nib_tx_en(nib_en));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic wait_commit(input logic [21:0] a, input logic [7:0] d);
        for (int i = 0; i < 4 && wr_valid !== 1'b1; i++) host.step();
        chk("wr_valid", 1, wr_valid);
        chk("wr_addr", a, wr_addr);
        chk("wr_data", d, wr_data);
        host.step();
        chk("wr_valid", 0, wr_valid);
    endtask : wait_commit
    // the run takes under fifty cycles; the ceiling leaves ample margin
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        reset_n = 1'b0;
        rd_data = 8'h00;
        nib_tx = 4'h0;
        nib_en = 1'b0;
        repeat (3) host.step();
        chk("int_rst_n", 0, int_rst_n);
        chk("wr_valid", 0, wr_valid);
        reset_n = 1'b1;
        host.step();
        host.step();
        chk("mode", 1, pmode);
        chk("frame", 1, frame);
        $display("test reset done");
        foreach (rows[i]) begin
            host.put_addr(rows[i].row, rows[i].col);
            host.step();
            chk("rd_addr", {rows[i].col, rows[i].row}, rd_addr);
            host.oe_n = 1'b0;
            rd_data = rows[i].d;
            #1 chk("dq_oe", 8'hFF, dq_oe);
            host.step();
            chk("pin", rows[i].d, pin);
            host.oe_n = 1'b1;
            #1 chk("dq_oe", 8'h00, dq_oe);
            // realign so the next row is driven one step after an edge
            host.step();
        end
        $display("test reads done");
        host.put_addr(11'h123, 11'h456);
        host.wr(8'h3C, 11'h0F0);
        wait_commit({11'h456, 11'h123}, 8'h3C);
        host.wr(8'hC3, 11'h00F);
        wait_commit({11'h0F0, 11'h123}, 8'hC3);
        $display("test writes done");
        reset_n = 1'b0;
        host.sel = 1'b0;
        repeat (3) host.step();
        reset_n = 1'b1;
        host.step();
        host.step();
        chk("mode", 0, pmode);
        // second reset held across an edge so it clears the hub flops
        host.oe_n = 1'b0;
        #1 chk("int_rst_n", 0, int_rst_n);
        host.step();
        chk("nibble", 4'h0, nib);
        host.oe_n = 1'b1;
        #1 chk("int_rst_n", 1, int_rst_n);
        host.step();
        host.we_n = 1'b0;
        host.dq = 8'hFA;
        host.rc = 1'b1;
        host.addr = 11'h555;
        host.step();
        chk("nibble", 4'hA, nib);
        chk("frame", 0, frame);
        host.rc = 1'b0;
        host.step();
        chk("rd_addr", 22'h000000, rd_addr);
        nib_tx = 4'h6;
        nib_en = 1'b1;
        #1 chk("dq_oe", 8'h0F, dq_oe);
        host.step();
        chk("pin", 4'h6, pin[3:0]);
        $display("test hub done");
        results();
    end
endmodule : fpmpp_port_tb
`default_nettype wire

// ---- hw/fpmpp_edge.sv ----
// edge detector for a pin sampled on the block clock
`timescale 1ns/100ps
`default_nettype none
module fpmpp_edge #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sig,
    output logic rise,
    output logic fall
);
    logic prev_ff;

    // ************************************************************
    // previous level
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= RST_VAL;
        end else begin
            prev_ff <= sig;
        end
    end

    assign rise = sig & ~prev_ff;
    assign fall = ~sig & prev_ff;
endmodule : fpmpp_edge
`default_nettype wire

// ---- hw/fpmpp_pkg.sv ----
// shared constants and types for the flash pin-mode and parallel port block
package fpmpp_pkg;
    // ************************************************************
    // pin widths
    // ************************************************************
    localparam int ADDR_PIN_W = 11;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic RST_STROBE_HI = 1'b1;
    localparam logic [ADDR_PIN_W-1:0] RST_ADDR = 11'h000;
    localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
    localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {
        FPMPP_HUB_MODE,
        FPMPP_PARALLEL_MODE
    } fpmpp_mode_t;
    typedef enum logic {
        FPMPP_WR_IDLE,
        FPMPP_WR_ACTIVE
    } fpmpp_wr_st_t;
endpackage : fpmpp_pkg

// ---- hw/fpmpp_port.sv ----
// pin-mode select and parallel programming port of a byte-wide flash
// Function
// R1: parallel mode drives data pins on reads, accepts them on writes.
// R2: write cycle captures data pins byte into an internal latch.
// R3: data outputs float whenever output-drive gate pin is high; here only in parallel mode, hub mode lanes follow hub_nib_tx_en.
// R4: low on second reset acts exactly like low on primary reset; here only in hub mode, and the mode strap is not re-sampled.
// R5: select pin high means parallel mode, low means hub serial mode.
// R6: system fixes select level before reset release and keeps it steady.
// R7: in parallel mode eleven address pins carry low-order address bits.
// R8: address is held internally for the whole write cycle.
// R9: row and column parts share pins and are captured by the strobe.
// R10: strobe level decides row or column meaning of address pins.
// R11: column goes to upper internal address bits, row to lower.
// R12: hub mode uses only the four nibble lines and frame input.
// R13: hub mode ignores parallel-only pins like strobe and upper data.
`timescale 1ns/100ps
`default_nettype none
module fpmpp_port #(
    parameter int ROW_W = fpmpp_pkg::ADDR_PIN_W,
    parameter int COL_W = fpmpp_pkg::ADDR_PIN_W
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic init_pin_n,
    input wire logic port_style_select,
    input wire logic [9:0] low_address_pins,
    input wire logic top_mux_address_pin,
    input wire logic row_col_sel,
    input wire logic we_frame_pin,
    input wire logic [fpmpp_pkg::DATA_W-1:0] dq_in,
    output logic [fpmpp_pkg::DATA_W-1:0] dq_out,
    output logic [fpmpp_pkg::DATA_W-1:0] dq_oe,
    output logic int_rst_n,
    output logic parallel_programming_mode,
    output logic [ROW_W+COL_W-1:0] core_rd_addr,
    input wire logic [fpmpp_pkg::DATA_W-1:0] core_rd_data,
    output logic core_wr_valid,
    output logic [ROW_W+COL_W-1:0] core_wr_addr,
    output logic [fpmpp_pkg::DATA_W-1:0] core_wr_data,
    output logic [fpmpp_pkg::NIB_W-1:0] hub_nibble_lines,
    output logic hub_frame_input,
    input wire logic [fpmpp_pkg::NIB_W-1:0] hub_nib_tx,
    input wire logic hub_nib_tx_en
);
    import fpmpp_pkg::*;

    if (ROW_W != ADDR_PIN_W || COL_W > ADDR_PIN_W || COL_W < 1) begin : g_bad_width
        $error("row width must match the pins and column width must fit them");
    end

    // ************************************************************
    // interface mode strap
    // ************************************************************
    fpmpp_mode_t mode_ff;
    fpmpp_mode_t nxt_mode;
    logic strap_done_ff;
    logic par_mode;

    // the strap is caught on the first edge after release, never at reset itself
    assign nxt_mode = port_style_select ? FPMPP_PARALLEL_MODE : FPMPP_HUB_MODE; // R5
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= FPMPP_HUB_MODE;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            mode_ff <= nxt_mode; // R6
            strap_done_ff <= 1'b1;
        end
    end
    assign par_mode = (mode_ff == FPMPP_PARALLEL_MODE);
    assign parallel_programming_mode = par_mode;

    // ************************************************************
    // reset merge
    // ************************************************************
    // the shared pin is an output gate in parallel mode, so it resets only in hub mode
    assign int_rst_n = reset_n & (par_mode | init_pin_n); // R4

    // ************************************************************
    // row and column capture
    // ************************************************************
    logic [ADDR_PIN_W-1:0] addr_pins;
    logic [ROW_W-1:0] row_ff;
    logic [COL_W-1:0] col_ff;
    logic row_load;
    logic col_load;

    assign addr_pins = {top_mux_address_pin, low_address_pins}; // R7
    assign row_load = par_mode & row_col_sel; // R10
    assign col_load = par_mode & ~row_col_sel; // R13
    always_ff @(posedge ref_clk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            row_ff <= RST_ADDR[ROW_W-1:0];
            col_ff <= RST_ADDR[COL_W-1:0];
        end else begin
            if (row_load) begin
                row_ff <= addr_pins[ROW_W-1:0]; // R9
            end
            if (col_load) begin
                col_ff <= addr_pins[COL_W-1:0]; // R9
            end
        end
    end
    assign core_rd_addr = {col_ff, row_ff}; // R11

    // ************************************************************
    // write cycle
    // ************************************************************
    fpmpp_wr_st_t wr_st_ff;
    fpmpp_wr_st_t nxt_wr_st;
    logic we_rise;
    logic we_fall;
    logic [ROW_W+COL_W-1:0] wr_addr_ff;
    logic [DATA_W-1:0] wr_data_ff;
    logic wr_valid_ff;
    logic addr_grab;
    logic data_grab;
    logic wr_done;

    fpmpp_edge #(
        .RST_VAL(RST_STROBE_HI)
    ) u_we_edge (
        .ref_clk(ref_clk),
        .rst_n(int_rst_n),
        .sig(we_frame_pin),
        .rise(we_rise),
        .fall(we_fall)
    );

    assign addr_grab = par_mode & we_fall & (wr_st_ff == FPMPP_WR_IDLE);
    assign data_grab = par_mode & ~we_frame_pin;
    assign wr_done = par_mode & we_rise & (wr_st_ff == FPMPP_WR_ACTIVE);

    always_comb begin
        nxt_wr_st = wr_st_ff;
        case (wr_st_ff)
            FPMPP_WR_IDLE: begin
                if (addr_grab) begin
                    nxt_wr_st = FPMPP_WR_ACTIVE;
                end
            end
            FPMPP_WR_ACTIVE: begin
                if (wr_done || !par_mode) begin
                    nxt_wr_st = FPMPP_WR_IDLE;
                end
            end
            default: begin
                nxt_wr_st = FPMPP_WR_IDLE;
            end
        endcase
    end

    // the row and column registers may move mid-write; the frozen copy is what commits
    always_ff @(posedge ref_clk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            wr_st_ff <= FPMPP_WR_IDLE;
            wr_addr_ff <= '0;
            wr_data_ff <= RST_DATA;
            wr_valid_ff <= 1'b0;
        end else begin
            wr_st_ff <= nxt_wr_st;
            wr_valid_ff <= wr_done;
            if (addr_grab) begin
                wr_addr_ff <= {col_ff, row_ff}; // R8
            end
            if (data_grab) begin
                wr_data_ff <= dq_in; // R2
            end
        end
    end
    assign core_wr_valid = wr_valid_ff;
    assign core_wr_addr = wr_addr_ff;
    assign core_wr_data = wr_data_ff;

    // ************************************************************
    // data pins and hub lines
    // ************************************************************
    logic [DATA_W-1:0] dq_out_ff;
    logic [DATA_W-1:0] nxt_dq_out;
    logic [NIB_W-1:0] hub_nib_ff;
    logic hub_frame_ff;
    logic par_read;
    logic [DATA_W-1:0] hub_oe;

    assign par_read = par_mode & ~init_pin_n & we_frame_pin; // R1
    // upper lanes carry nothing in hub mode
    assign nxt_dq_out = par_mode ? core_rd_data : {{(DATA_W-NIB_W){1'b0}}, hub_nib_tx}; // R12
    assign hub_oe = {{(DATA_W-NIB_W){1'b0}}, {NIB_W{hub_nib_tx_en}}}; // R12
    assign dq_oe = par_mode ? {DATA_W{par_read}} : hub_oe; // R3
    always_ff @(posedge ref_clk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            dq_out_ff <= RST_DATA;
            hub_nib_ff <= RST_NIB;
            hub_frame_ff <= RST_STROBE_HI;
        end else begin
            dq_out_ff <= nxt_dq_out; // R1
            hub_nib_ff <= par_mode ? RST_NIB : dq_in[NIB_W-1:0]; // R12
            hub_frame_ff <= par_mode ? RST_STROBE_HI : we_frame_pin; // R12
        end
    end
    assign dq_out = dq_out_ff;
    assign hub_nibble_lines = hub_nib_ff;
    assign hub_frame_input = hub_frame_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!int_rst_n);

    property p_read_drive;
        par_read |-> (dq_oe == {DATA_W{1'b1}}) ##1 (dq_out == $past(core_rd_data));
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven"); // R1

    property p_wr_data;
        core_wr_valid |-> (core_wr_data == $past(dq_in, 2));
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data wrong"); // R2

    property p_tristate;
        (par_mode && init_pin_n) |-> (dq_oe == '0);
    endproperty
    a_tristate: assert property (p_tristate) else $error("data driven with gate high"); // R3

    property p_reset_merge;
        @(posedge ref_clk) disable iff (!reset_n)
        (!par_mode && !init_pin_n) |-> !int_rst_n;
    endproperty
    a_reset_merge: assert property (p_reset_merge) else $error("second reset ignored"); // R4

    property p_mode_strap;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(strap_done_ff) |-> (par_mode == $past(port_style_select)) ##1
            $stable(par_mode)[*3];
    endproperty
    a_mode_strap: assert property (p_mode_strap) else $error("mode not from strap"); // R5

    property p_addr_hold;
        (wr_st_ff == FPMPP_WR_ACTIVE) && $past(wr_st_ff == FPMPP_WR_ACTIVE) |-> $stable(wr_addr_ff);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("write address moved"); // R8

    property p_wr_commit;
        wr_done |=> core_wr_valid ##1 !core_wr_valid;
    endproperty
    a_wr_commit: assert property (p_wr_commit) else $error("write pulse wrong"); // R2

    property p_row_col;
        (par_mode && row_col_sel) ##1 (par_mode && !row_col_sel) |=>
            (core_rd_addr == {$past(addr_pins[COL_W-1:0]), $past(addr_pins[ROW_W-1:0], 2)});
    endproperty
    a_row_col: assert property (p_row_col) else $error("row column mapping wrong"); // R11

    property p_hub_ignore;
        !par_mode |=> $stable(row_ff) && $stable(col_ff) && !core_wr_valid;
    endproperty
    a_hub_ignore: assert property (p_hub_ignore) else $error("parallel pins used in hub mode"); // R13

    property p_hub_lanes;
        !par_mode |-> (dq_oe[DATA_W-1:NIB_W] == '0) ##1
            (hub_nibble_lines == $past(dq_in[NIB_W-1:0]));
    endproperty
    a_hub_lanes: assert property (p_hub_lanes) else $error("hub lanes wrong"); // R12

    c_write: cover property (wr_done ##1 core_wr_valid);
    c_read: cover property (par_read [*3]);
    c_row_then_col: cover property ((par_mode && row_col_sel) ##1 (par_mode && !row_col_sel));
    c_hub_tx: cover property (!par_mode && hub_nib_tx_en);
endmodule : fpmpp_port
`default_nettype wire
